/* design/cell_protection_pkg.sv */
// Constants, register layout and helpers of the cell protection control block
package cell_protection_pkg;
	// Bus geometry
	localparam int ADDR_WIDTH = 18;
	localparam int DATA_WIDTH = 32;
	localparam int REG_WIDTH  = 16;
	// Register indexes, byte address is four times the index
	localparam logic [15:0] STAT_INDEX       = 16'h0000;
	localparam logic [15:0] TRIM_KEY_INDEX   = 16'h001D;
	localparam logic [15:0] TRIM_GAIN_INDEX  = 16'h001E;
	localparam logic [15:0] TRIM_LIMIT_INDEX = 16'h001F;
	localparam logic [15:0] ADC_CONFIG_INDEX = 16'h600A;
	localparam int          TRIM_WORDS       = 3;
	localparam int          TRIM_INDEX_WIDTH = 2;
	// Protection register fields
	localparam int FLAG_LSB        = 11;
	localparam int FLAG_COUNT      = 5;
	localparam int CHG_OC_FLAG_BIT = 4;
	localparam int DSG_OC_FLAG_BIT = 3;
	localparam int SHORT_FLAG_BIT  = 2;
	localparam int HIGH_V_FLAG_BIT = 1;
	localparam int LOW_V_FLAG_BIT  = 0;
	localparam int CHG_MIRROR_BIT  = 9;
	localparam int DSG_MIRROR_BIT  = 8;
	localparam int CHG_ALLOW_BIT   = 3;
	localparam int DSG_ALLOW_BIT   = 2;
	localparam int MODE_LSB        = 0;
	// Mode codes
	localparam logic [1:0] MODE_OFF      = 2'h0;
	localparam logic [1:0] MODE_RELEASED = 2'h3;
	// Reset values
	localparam logic       CHG_ALLOW_RESET  = 1'h1;
	localparam logic       DSG_ALLOW_RESET  = 1'h1;
	localparam logic [1:0] MODE_RESET       = 2'h0;
	localparam logic [15:0] TRIM_RESET      = 16'h0000;
	localparam logic [15:0] ADC_CONFIG_RESET = 16'h0000;
	// Trim fields and defaults
	localparam logic [7:0] TRIM_KEY_VALID      = 8'h76;
	localparam int         SLAVE_ADDR_LSB      = 8;
	localparam logic [6:0] SLAVE_ADDR_DEFAULT  = 7'h0B;
	localparam int         GAIN_LSB            = 8;
	localparam logic [7:0] GAIN_DEFAULT        = 8'h00; // Arbitrary factory value
	localparam int         TEMPCO_LSB          = 0;
	localparam logic [7:0] TEMPCO_DEFAULT      = 8'h00;
	localparam int         TEMP_LIMIT_EN_BIT   = 7;
	localparam logic       TEMP_LIMIT_EN_DEFAULT = 1'h0;
	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// Word index of a byte address
	function automatic logic [15:0] word_index(input logic [ADDR_WIDTH-1:0] addr);
		return addr[ADDR_WIDTH-1:2];
	endfunction : word_index

	// Merge a 16-bit word under two byte strobes
	function automatic logic [15:0] merge_bytes(input logic [15:0] old,
			input logic [15:0] data, input logic [1:0] strobe);
		return {strobe[1] ? data[15:8] : old[15:8], strobe[0] ? data[7:0] : old[7:0]};
	endfunction : merge_bytes
endpackage : cell_protection_pkg

/* design/fault_flag_bank.sv */
// Sticky fault flags with software clear
`timescale 1ns/1ps
module fault_flag_bank #(
	parameter int COUNT = 5
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Live fault levels and clear requests
	input  wire logic [COUNT-1:0] faultActive,
	input  wire logic [COUNT-1:0] clearRequest,
	// Flag state
	output logic      [COUNT-1:0] flags_q
);
	logic [COUNT-1:0] flags_d;

	if (COUNT < 1) begin : badCount
		$error("fault_flag_bank needs at least one flag");
	end

	// Live fault sets and holds; clear only lands once the fault is gone
	assign flags_d = faultActive | (flags_q & ~clearRequest);

	// Flag storage
	always_ff @(posedge clk) begin
		if (rst) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end
endmodule : fault_flag_bank

/* design/trim_store.sv */
// Small rewritable trim word store with registered read port
`timescale 1ns/1ps
module trim_store #(
	parameter int          WORDS       = 3,
	parameter int          INDEX_WIDTH = 2,
	parameter logic [15:0] RESET_WORD  = 16'h0000
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst,
	// Write port
	input  wire logic                   writeEnable,
	input  wire logic [INDEX_WIDTH-1:0] writeIndex,
	input  wire logic [1:0]             writeBytes,
	input  wire logic [15:0]            writeData,
	// Read port
	input  wire logic [INDEX_WIDTH-1:0] readIndex,
	output logic      [15:0]            readData_q,
	// Whole contents for the trim selection
	output logic      [WORDS*16-1:0]    contents_q
);
	import cell_protection_pkg::*;

	logic [15:0] mem_q [WORDS];

	if (WORDS < 1 || WORDS > (1 << INDEX_WIDTH)) begin : badSize
		$error("trim_store word count does not fit its index");
	end

	// Word storage with byte writes
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < WORDS; i++) begin
				mem_q[i] <= RESET_WORD;
			end
		end else if (writeEnable && int'(writeIndex) < WORDS) begin
			mem_q[writeIndex] <= merge_bytes(mem_q[writeIndex], writeData, writeBytes);
		end
	end

	// Registered read, out of range reads zero
	always_ff @(posedge clk) begin
		if (rst) begin
			readData_q <= 16'h0000;
		end else begin
			readData_q <= (int'(readIndex) < WORDS) ? mem_q[readIndex] : 16'h0000;
		end
	end

	// Flattened view of the stored words
	for (genvar g = 0; g < WORDS; g++) begin : flat
		assign contents_q[g*16 +: 16] = mem_q[g];
	end
endmodule : trim_store

/* design/cell_protection_control.sv */
// Protection register, FET gating, trim selection and AXI4-Lite slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module cell_protection_control (
	// Clock and reset
	input  wire logic                                  clk,
	input  wire logic                                  rst,
	// AXI4-Lite write address
	input  wire logic [cell_protection_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,
	input  wire logic [2:0]                            s_axi_awprot,
	input  wire logic                                  s_axi_awvalid,
	output logic                                       s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [cell_protection_pkg::DATA_WIDTH-1:0] s_axi_wdata,
	input  wire logic [3:0]                            s_axi_wstrb,
	input  wire logic                                  s_axi_wvalid,
	output logic                                       s_axi_wready,
	// AXI4-Lite write response
	output logic      [1:0]                            s_axi_bresp,
	output logic                                       s_axi_bvalid,
	input  wire logic                                  s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [cell_protection_pkg::ADDR_WIDTH-1:0] s_axi_araddr,
	input  wire logic [2:0]                            s_axi_arprot,
	input  wire logic                                  s_axi_arvalid,
	output logic                                       s_axi_arready,
	// AXI4-Lite read data
	output logic      [cell_protection_pkg::DATA_WIDTH-1:0] s_axi_rdata,
	output logic      [1:0]                            s_axi_rresp,
	output logic                                       s_axi_rvalid,
	input  wire logic                                  s_axi_rready,
	// Fault conditions from the analog protection comparators
	input  wire logic                                  chargeOvercurrentFault,
	input  wire logic                                  dischargeOvercurrentFault,
	input  wire logic                                  shortedLoadFault,
	input  wire logic                                  highCellVoltageFault,
	input  wire logic                                  lowCellVoltageFault,
	input  wire logic                                  chargeTempFault,
	input  wire logic                                  dischargeTempFault,
	input  wire logic                                  sleepActive,
	// FET gate switch controls
	output logic                                       chargeGateToPump,
	output logic                                       chargeGateToSupply,
	output logic                                       dischargeGateToPump,
	output logic                                       dischargeGateToGround,
	// Converter control and thresholds
	output logic                                       converterEnable,
	output logic      [15:0]                           converterConfig,
	// Selected trim values
	output logic                                       userTrimActive,
	output logic      [6:0]                            slaveAddress,
	output logic      [7:0]                            currentGainTrim,
	output logic      [7:0]                            senseResistorTempco,
	output logic                                       tempLimitEnable
);
	import cell_protection_pkg::*;

	// Input synchroniser, first stage read only by the second
	logic [7:0] pinMeta_q;
	logic [7:0] pinSync_q;
	wire  [7:0] pinRaw = {sleepActive, dischargeTempFault, chargeTempFault,
		lowCellVoltageFault, highCellVoltageFault, shortedLoadFault,
		dischargeOvercurrentFault, chargeOvercurrentFault};

	always_ff @(posedge clk) begin
		if (rst) begin
			pinMeta_q <= 8'h00;
			pinSync_q <= 8'h00;
		end else begin
			pinMeta_q <= pinRaw;
			pinSync_q <= pinMeta_q;
		end
	end

	// Named synchronised fault levels
	wire chgOcLive = pinSync_q[0];
	wire dsgOcLive = pinSync_q[1];
	wire shortLive = pinSync_q[2];
	wire highVLive = pinSync_q[3];
	wire lowVLive  = pinSync_q[4];
	wire chgTemp   = pinSync_q[5];
	wire dsgTemp   = pinSync_q[6];
	wire asleep    = pinSync_q[7];

	// Software control bits and converter configuration
	logic       chargeAllow_q;
	logic       chargeAllow_d;
	logic       dischargeAllow_q;
	logic       dischargeAllow_d;
	logic [1:0] protectMeasureMode_q;
	logic [1:0] protectMeasureMode_d;
	logic [15:0] adcConfig_q;
	logic [15:0] adcConfig_d;
	logic       chargeFetControl_q;
	logic       dischargeFetControl_q;
	logic [FLAG_COUNT-1:0] faultFlags_q;

	// Write channel state
	logic        awHeld_q;
	logic        wHeld_q;
	logic [15:0] awIndex_q;
	logic [15:0] wData_q;
	logic [1:0]  wStrb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;

	// Read channel state
	logic        rdStage_q;
	logic [15:0] arIndex_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	// Channel readiness
	assign s_axi_awready = !awHeld_q && !bvalid_q;
	assign s_axi_wready  = !wHeld_q && !bvalid_q;
	assign s_axi_arready = !rdStage_q && !rvalid_q;
	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake  = s_axi_wvalid && s_axi_wready;
	wire arTake = s_axi_arvalid && s_axi_arready;

	// Write commit once address and data are both held
	wire doWrite   = awHeld_q && wHeld_q && !bvalid_q;
	wire wrStat    = doWrite && awIndex_q == STAT_INDEX;
	wire wrAdc     = doWrite && awIndex_q == ADC_CONFIG_INDEX;
	wire wrTrim    = doWrite && awIndex_q >= TRIM_KEY_INDEX && awIndex_q <= TRIM_LIMIT_INDEX;
	wire wrMapped  = wrStat || wrAdc || wrTrim;
	wire [15:0] trimWrOffset = awIndex_q - TRIM_KEY_INDEX;

	// Address and data capture
	always_ff @(posedge clk) begin
		if (rst) begin
			awHeld_q  <= 1'b0;
			awIndex_q <= 16'h0000;
		end else if (awTake) begin
			awHeld_q  <= 1'b1;
			awIndex_q <= word_index(s_axi_awaddr);
		end else if (doWrite) begin
			awHeld_q  <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wHeld_q <= 1'b0;
			wData_q <= 16'h0000;
			wStrb_q <= 2'h0;
		end else if (wTake) begin
			wHeld_q <= 1'b1;
			wData_q <= s_axi_wdata[15:0];
			wStrb_q <= s_axi_wstrb[1:0];
		end else if (doWrite) begin
			wHeld_q <= 1'b0;
		end
	end

	// Write response, decode error for unmapped words
	always_ff @(posedge clk) begin
		if (rst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wrMapped ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// Protection register write; reserved bits are never stored
	wire [15:0] statMerged = merge_bytes(16'h0000, wData_q, wStrb_q);
	assign chargeAllow_d = (wrStat && wStrb_q[0]) ? statMerged[CHG_ALLOW_BIT]
		: chargeAllow_q;
	assign dischargeAllow_d = (wrStat && wStrb_q[0]) ? statMerged[DSG_ALLOW_BIT]
		: dischargeAllow_q;
	assign protectMeasureMode_d = (wrStat && wStrb_q[0]) ? statMerged[MODE_LSB +: 2]
		: protectMeasureMode_q;
	assign adcConfig_d = wrAdc ? merge_bytes(adcConfig_q, wData_q, wStrb_q)
		: adcConfig_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			chargeAllow_q        <= CHG_ALLOW_RESET;
			dischargeAllow_q     <= DSG_ALLOW_RESET;
			protectMeasureMode_q <= MODE_RESET;
			adcConfig_q          <= ADC_CONFIG_RESET;
		end else begin
			chargeAllow_q        <= chargeAllow_d;
			dischargeAllow_q     <= dischargeAllow_d;
			protectMeasureMode_q <= protectMeasureMode_d;
			adcConfig_q          <= adcConfig_d;
		end
	end

	// Flag clears: a zero written in the upper byte asks to clear
	wire [FLAG_COUNT-1:0] flagClear = (wrStat && wStrb_q[1])
		? ~statMerged[FLAG_LSB +: FLAG_COUNT] : '0;
	wire [FLAG_COUNT-1:0] faultLive = {chgOcLive, dsgOcLive, shortLive, highVLive,
		lowVLive};

	fault_flag_bank #(
		.COUNT        (FLAG_COUNT)
	) flagBank (
		.clk          (clk),
		.rst          (rst),
		.faultActive  (faultLive),
		.clearRequest (flagClear),
		.flags_q      (faultFlags_q)
	);

	// Trim word store
	logic [15:0]            trimReadData_q;
	logic [TRIM_WORDS*16-1:0] trimContents_q;
	wire  [15:0] arIndexNow  = word_index(s_axi_araddr);
	wire  [15:0] trimRdOffset = arIndexNow - TRIM_KEY_INDEX;

	trim_store #(
		.WORDS       (TRIM_WORDS),
		.INDEX_WIDTH (TRIM_INDEX_WIDTH),
		.RESET_WORD  (TRIM_RESET)
	) trimStore (
		.clk         (clk),
		.rst         (rst),
		.writeEnable (wrTrim),
		.writeIndex  (trimWrOffset[TRIM_INDEX_WIDTH-1:0]),
		.writeBytes  (wStrb_q),
		.writeData   (wData_q),
		.readIndex   (trimRdOffset[TRIM_INDEX_WIDTH-1:0]),
		.readData_q  (trimReadData_q),
		.contents_q  (trimContents_q)
	);

	// Trim selection, all values follow the single key check
	wire [15:0] keyWord   = trimContents_q[0 +: 16];
	wire [15:0] gainWord  = trimContents_q[16 +: 16];
	wire [15:0] limitWord = trimContents_q[32 +: 16];
	wire        keyValid  = keyWord[7:0] == TRIM_KEY_VALID;
	wire        tempEnSel = keyValid ? limitWord[TEMP_LIMIT_EN_BIT]
		: TEMP_LIMIT_EN_DEFAULT;

	// Trim outputs registered
	always_ff @(posedge clk) begin
		if (rst) begin
			userTrimActive      <= 1'b0;
			slaveAddress        <= SLAVE_ADDR_DEFAULT;
			currentGainTrim     <= GAIN_DEFAULT;
			senseResistorTempco <= TEMPCO_DEFAULT;
			tempLimitEnable     <= TEMP_LIMIT_EN_DEFAULT;
		end else begin
			userTrimActive      <= keyValid;
			slaveAddress        <= keyValid ? keyWord[SLAVE_ADDR_LSB +: 7]
				: SLAVE_ADDR_DEFAULT;
			currentGainTrim     <= keyValid ? gainWord[GAIN_LSB +: 8]
				: GAIN_DEFAULT;
			senseResistorTempco <= keyValid ? gainWord[TEMPCO_LSB +: 8]
				: TEMPCO_DEFAULT;
			tempLimitEnable     <= tempEnSel;
		end
	end

	// FET permission, faults override software; temperature faults only while the selected temp limit enable is set
	wire modeReleased = protectMeasureMode_q == MODE_RELEASED;
	wire chargeOk = !highVLive && !lowVLive && !chgOcLive && !(tempEnSel && chgTemp)
		&& chargeAllow_q && modeReleased && !asleep;
	wire dischargeOk = !lowVLive && !chgOcLive && !dsgOcLive && !shortLive
		&& !(tempEnSel && dsgTemp) && dischargeAllow_q
		&& modeReleased && !asleep;

	// FET control state and converter enable
	always_ff @(posedge clk) begin
		if (rst) begin
			chargeFetControl_q    <= 1'b0;
			dischargeFetControl_q <= 1'b0;
			converterEnable       <= 1'b0;
		end else begin
			chargeFetControl_q    <= chargeOk;
			dischargeFetControl_q <= dischargeOk;
			converterEnable       <= protectMeasureMode_q != MODE_OFF;
		end
	end

	// Gate switches: pump when on, rail or ground when off
	assign chargeGateToPump      = chargeFetControl_q;
	assign chargeGateToSupply    = !chargeFetControl_q;
	assign dischargeGateToPump   = dischargeFetControl_q;
	assign dischargeGateToGround = !dischargeFetControl_q;
	assign converterConfig       = adcConfig_q;

	// Protection register read view, reserved bits zero
	wire [15:0] statView = {faultFlags_q, 1'b0, chargeFetControl_q, dischargeFetControl_q,
		4'h0, chargeAllow_q, dischargeAllow_q, protectMeasureMode_q};

	// Read decode on the held index
	wire rdStat   = arIndex_q == STAT_INDEX;
	wire rdAdc    = arIndex_q == ADC_CONFIG_INDEX;
	wire rdTrim   = arIndex_q >= TRIM_KEY_INDEX && arIndex_q <= TRIM_LIMIT_INDEX;
	wire [15:0] rdWord = rdStat ? statView : rdAdc ? adcConfig_q
		: rdTrim ? trimReadData_q : 16'h0000;

	// Read pipeline: index held, then data registered
	always_ff @(posedge clk) begin
		if (rst) begin
			rdStage_q <= 1'b0;
			arIndex_q <= 16'h0000;
		end else if (arTake) begin
			rdStage_q <= 1'b1;
			arIndex_q <= arIndexNow;
		end else begin
			rdStage_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= RESP_OKAY;
		end else if (rdStage_q) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {16'h0000, rdWord};
			rresp_q  <= (rdStat || rdAdc || rdTrim) ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;
endmodule : cell_protection_control

/* verification/cell_protection_monitor.sv */
// Port checker for the cell protection control block
`timescale 1ns/1ps
module cell_protection_monitor (
	// Clock and reset
	input wire logic                                       clk,
	input wire logic                                       rst,
	// Bus answers
	input wire logic                                       s_axi_bvalid,
	input wire logic                                       s_axi_bready,
	input wire logic [1:0]                                 s_axi_bresp,
	input wire logic                                       s_axi_rvalid,
	input wire logic                                       s_axi_rready,
	input wire logic [cell_protection_pkg::DATA_WIDTH-1:0] s_axi_rdata,
	// Fault levels
	input wire logic                                       highCellVoltageFault,
	input wire logic                                       shortedLoadFault,
	input wire logic                                       sleepActive,
	// Gates, converter and trim
	input wire logic                                       chargeGateToPump,
	input wire logic                                       chargeGateToSupply,
	input wire logic                                       dischargeGateToPump,
	input wire logic                                       dischargeGateToGround,
	input wire logic                                       converterEnable,
	input wire logic                                       userTrimActive,
	input wire logic [6:0]                                 slaveAddress,
	input wire logic [7:0]                                 currentGainTrim,
	input wire logic [7:0]                                 senseResistorTempco,
	input wire logic                                       tempLimitEnable
);
	import cell_protection_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Gate switches are exclusive
	a_chg_switch_excl: assert property (
		chargeGateToSupply == !chargeGateToPump)
		else $error("charge gate switches not exclusive");
	a_dsg_switch_excl: assert property (
		dischargeGateToGround == !dischargeGateToPump)
		else $error("discharge gate switches not exclusive");
	// Faults and sleep hold the FETs off, two sync stages plus the gate register
	a_highv_blocks_chg: assert property (
		highCellVoltageFault [*4] |-> !chargeGateToPump)
		else $error("charge gate on during high voltage");
	a_short_blocks_dsg: assert property (
		shortedLoadFault [*4] |-> !dischargeGateToPump)
		else $error("discharge gate on during short");
	a_sleep_gates_off: assert property (
		sleepActive [*4] |-> !chargeGateToPump && !dischargeGateToPump)
		else $error("gate on while asleep");
	a_mode_off_gates: assert property (
		!converterEnable |-> !chargeGateToPump && !dischargeGateToPump)
		else $error("gate on with converter off");
	a_trim_default: assert property (
		!userTrimActive |-> slaveAddress == SLAVE_ADDR_DEFAULT && currentGainTrim == GAIN_DEFAULT
		&& senseResistorTempco == TEMPCO_DEFAULT && !tempLimitEnable)
		else $error("defaults not used with invalid key");
	// Bus answers stand until taken
	a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_both_on: cover property (chargeGateToPump && dischargeGateToPump);
endmodule : cell_protection_monitor

bind cell_protection_control cell_protection_monitor i_cell_protection_monitor (.*);

/* verification/fet_fault_model.sv */
// Comparator and FET model at the far side of the protection block
`timescale 1ns/1ps
module fet_fault_model (
	// Clock
	input  wire logic       clk,
	// Requested levels, msb first: charge and discharge overcurrent, short, high, low, temps, sleep
	input  wire logic [7:0] faultCmd,
	// Gate switches from the block
	input  wire logic       chgPump,
	input  wire logic       chgSupply,
	input  wire logic       dsgPump,
	input  wire logic       dsgGround,
	// Comparator levels and resolved FET states
	output logic      [7:0] faultLevel,
	output logic            chargeOn,
	output logic            dischargeOn
);
	// Comparators move just after the edge
	always_ff @(posedge clk) begin
		faultLevel <= faultCmd;
	end
	// Gate at pump level only with the pump switch alone closed
	assign chargeOn    = chgPump & ~chgSupply;
	assign dischargeOn = dsgPump & ~dsgGround;
endmodule : fet_fault_model

/* verification/tb.sv */
// Self-checking bench for the cell protection control block
`timescale 1ns/1ps
module tb;
	import cell_protection_pkg::*;
	logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [17:0] awa = '0, ara = '0;
	logic [31:0] wd = '0, rd;
	logic [7:0] faultCmd = '0;
	logic [3:0] ws = 4'hF;
	logic [1:0] rs;
	wire logic awr, wr, bv, arr, rv, cgp, cgs, dgp, dgg, chgOn, dsgOn, conv, trimOn, tempEn;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [7:0] fl, gain, tco;
	wire logic [15:0] cfg;
	wire logic [6:0] slv;
	int bad_count = 0, checks_done = 0;
	always #5 clk = ~clk;
	cell_protection_control i_cell_protection_control (.clk(clk), .rst(rst),
		.s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
		.chargeOvercurrentFault(fl[7]), .dischargeOvercurrentFault(fl[6]),
		.shortedLoadFault(fl[5]), .highCellVoltageFault(fl[4]), .lowCellVoltageFault(fl[3]),
		.chargeTempFault(fl[2]), .dischargeTempFault(fl[1]), .sleepActive(fl[0]),
		.chargeGateToPump(cgp), .chargeGateToSupply(cgs), .dischargeGateToPump(dgp),
		.dischargeGateToGround(dgg), .converterEnable(conv), .converterConfig(cfg),
		.userTrimActive(trimOn), .slaveAddress(slv), .currentGainTrim(gain),
		.senseResistorTempco(tco), .tempLimitEnable(tempEn));
	fet_fault_model i_fet_fault_model (.clk(clk), .faultCmd(faultCmd), .chgPump(cgp),
		.chgSupply(cgs), .dsgPump(dgp), .dsgGround(dgg), .faultLevel(fl),
		.chargeOn(chgOn), .dischargeOn(dsgOn));
	// Value compare
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Bus write, both channels offered together
	task automatic axw(input logic [17:0] a, input logic [15:0] d);
		@(posedge clk);
		awa <= a;
		wd <= {16'h0000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
		end while (!bv);
		rs = bresp;
		br <= 1'b0;
	endtask : axw
	// Bus read
	task automatic axr(input logic [17:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end while (!rv);
		rd = rdata;
		rs = rresp;
		rr <= 1'b0;
	endtask : axr
	// Let outputs settle past an edge
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	task automatic t_reset();
		axr(18'h00000);
		chk("status reset", 32'h0000000C, rd);
		chk("addr reset", 32'h0B, slv);
		axw(18'h00000, 16'hFFFF);
		axr(18'h00000);
		chk("status all ones", 32'h0000030F, rd);
	endtask : t_reset
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			axw(18'h00000, 16'h000C | 16'(m));
			wt(2);
			chk("mode outs", {m == 3, m == 3, m != 0}, {chgOn, dsgOn, conv});
		end
		axw(18'h00000, 16'h0007);
		wt(2);
		chk("chg allow", 2'b01, {chgOn, dsgOn});
		axw(18'h00000, 16'h000B);
		wt(2);
		chk("dsg allow", 2'b10, {chgOn, dsgOn});
	endtask : t_modes
	task automatic t_faults();
		logic [4:0] f;
		logic co, dok;
		for (int i = 0; i < 5; i++) begin
			f = 5'h10 >> i;
			co = ~|(f & 5'b10011);
			dok = ~|(f & 5'b11101);
			axw(18'h00000, 16'h000F);
			faultCmd <= {f, 3'h0};
			wt(5);
			axw(18'h00000, 16'h000F);
			wt(2);
			chk("fault gates", {co, dok}, {chgOn, dsgOn});
			axr(18'h00000);
			chk("fault flag", {f, 1'b0, co, dok, 8'h0F}, rd);
			faultCmd <= 8'h00;
			wt(5);
			axr(18'h00000);
			chk("flag sticks", {f, 11'h30F}, rd);
			// Low lane only: the flag byte is not written, so no clear
			ws <= 4'h1;
			axw(18'h00000, 16'h000F);
			ws <= 4'hF;
			axr(18'h00000);
			chk("flag lane", {f, 11'h30F}, rd);
			axw(18'h00000, 16'h000F);
			axr(18'h00000);
			chk("flag cleared", 32'h030F, rd);
		end
	endtask : t_faults
	task automatic t_trim();
		axw(18'h0007C, 16'h0080);
		faultCmd <= 8'h06;
		wt(5);
		chk("temp ignored", 2'b11, {chgOn, dsgOn});
		axw(18'h00074, 16'h2A76);
		axw(18'h00078, 16'hA41A);
		wt(3);
		chk("user trim flags", 2'b11, {trimOn, tempEn});
		chk("user trim addr", 7'h2A, slv);
		chk("user trim gain", 16'hA41A, {gain, tco});
		chk("temp gates", 2'b00, {chgOn, dsgOn});
		axr(18'h00074);
		chk("key word", 32'h2A76, rd);
		axw(18'h00074, 16'h2A77);
		wt(3);
		chk("bad key flags", 2'b00, {trimOn, tempEn});
		chk("bad key addr", 7'h0B, slv);
		chk("bad key gain", {GAIN_DEFAULT, 8'h00}, {gain, tco});
		faultCmd <= 8'h01;
		wt(5);
		chk("sleep gates", 2'b00, {chgOn, dsgOn});
		axr(18'h00000);
		chk("sleep mirror", 32'h000F, rd);
		faultCmd <= 8'h00;
	endtask : t_trim
	task automatic t_bus();
		axw(18'h18028, 16'h1234);
		wt(2);
		chk("config out", 32'h1234, cfg);
		axr(18'h18028);
		chk("config read", 32'h1234, rd);
		chk("config resp", RESP_OKAY, rs);
		axw(18'h00100, 16'h5555);
		chk("unmapped wr", RESP_DECERR, rs);
		axr(18'h00100);
		chk("unmapped rd resp", RESP_DECERR, rs);
		chk("unmapped rd data", 32'h0, rd);
	endtask : t_bus
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		#200000;
		bad_count++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_modes();
		t_faults();
		t_trim();
		t_bus();
		finish_test();
	end
endmodule : tb
